// ===== rtl/pcxcfg_ext_space.sv
`timescale 1ns/100ps
`default_nettype none
module pcxcfg_ext_space #(
    parameter logic [15:0] VENDOR_CODE = 16'h1a2b, // arbitrary value
    parameter logic [15:0] DEVICE_CODE = 16'h3c4d, // arbitrary value
    parameter logic [31:0] REPLAY_RST  = 32'h0000_0000
) (
    input  wire logic                          I_REF_CLK,
    input  wire logic                          I_RESETN,
    input  wire logic                          I_PWR_RESETN,
    input  wire logic                          I_SUBTR_DEC_EN,
    input  wire logic                          I_CFG_REQ,
    input  wire logic                          I_CFG_WE,
    input  wire pcxcfg_pkg::pcxcfg_src_t       I_CFG_SRC,
    input  wire logic [pcxcfg_pkg::AW-1:0]     I_CFG_ADDR,
    input  wire logic [3:0]                    I_CFG_BE,
    input  wire logic [pcxcfg_pkg::DW-1:0]     I_CFG_WDATA,
    output logic                               O_CFG_ACK,
    output logic      [pcxcfg_pkg::DW-1:0]     O_CFG_RDATA,
    input  wire logic [31:0]                   I_UNC_ERR_SET,
    input  wire logic [31:0]                   I_COR_ERR_SET,
    input  wire logic [31:0]                   I_SEC_UNC_SET,
    input  wire logic [127:0]                  I_HDR_LOG,
    input  wire logic [127:0]                  I_SEC_HDR_LOG,
    input  wire logic [pcxcfg_pkg::PIN_W-1:0]  I_XPIN_IN,
    output logic      [pcxcfg_pkg::PIN_W-1:0]  O_XPIN_OUT,
    output logic      [pcxcfg_pkg::PIN_W-1:0]  O_XPIN_OE_N,
    input  wire logic [pcxcfg_pkg::PIN_W-1:0]  I_GEN_IN,
    output logic      [pcxcfg_pkg::PIN_W-1:0]  O_GEN_OUT,
    output logic      [31:0]                   O_REPLAY_TIMER
);
    import pcxcfg_pkg::*;

    function automatic logic [31:0] merge(input logic [31:0] q,
                                          input logic [31:0] d,
                                          input logic [31:0] m);
        merge = (q & ~m) | (d & m);
    endfunction

    function automatic logic [4:0] low_idx(input logic [31:0] v);
        low_idx = 5'h00;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                low_idx = 5'(i);
            end
        end
    endfunction

    logic [11:0]             waddr;
    logic [11:0]             hrel;
    logic [11:0]             srel;
    logic [31:0]             bm;
    logic [31:0]             wd;
    logic                    hit;
    logic                    blank;
    logic                    src_ok;
    logic                    acc_rd;
    logic                    acc_wr;
    logic [31:0]             rd_word;
    logic [31:0]             unc_flags;
    logic [31:0]             cor_flags;
    logic [31:0]             sec_flags;
    logic [31:0]             unc_new;
    logic [31:0]             sec_new;
    logic [PIN_W-1:0]        pin_s1_q;
    logic [PIN_W-1:0]        pin_s2_q;
    logic [PIN_W-1:0]        gen_s1_q;
    logic [PIN_W-1:0]        gen_s2_q;
    logic                    ack_q;
    logic                    ack_d;
    logic [31:0]             rdata_q;
    logic [31:0]             rdata_d;
    logic [31:0]             pin_q;
    logic [31:0]             pin_d;
    logic [31:0]             io_q;
    logic [31:0]             io_d;
    logic [31:0]             replay_q;
    logic [31:0]             replay_d;
    logic [31:0]             pch_q;
    logic [31:0]             pch_d;
    logic [31:0]             ch0_q;
    logic [31:0]             ch0_d;
    logic [31:0]             unc_mask_q;
    logic [31:0]             unc_mask_d;
    logic [31:0]             unc_sev_q;
    logic [31:0]             unc_sev_d;
    logic [31:0]             cor_mask_q;
    logic [31:0]             cor_mask_d;
    logic [31:0]             ctrl_q;
    logic [31:0]             ctrl_d;
    logic [4:0]              fep_q;
    logic [4:0]              fep_d;
    logic [3:0][31:0]        hdr_q;
    logic [3:0][31:0]        hdr_d;
    logic [31:0]             sec_mask_q;
    logic [31:0]             sec_mask_d;
    logic [31:0]             sec_sev_q;
    logic [31:0]             sec_sev_d;
    logic [31:0]             sec_ctrl_q;
    logic [31:0]             sec_ctrl_d;
    logic [4:0]              sec_fep_q;
    logic [4:0]              sec_fep_d;
    logic [3:0][31:0]        sec_hdr_q;
    logic [3:0][31:0]        sec_hdr_d;

    assign waddr = {I_CFG_ADDR[11:2], 2'h0};
    assign hrel  = waddr - OFS_HDR_LOG;
    assign srel  = waddr - OFS_SEC_HDR;
    assign bm    = {{8{I_CFG_BE[3]}}, {8{I_CFG_BE[2]}},
                    {8{I_CFG_BE[1]}}, {8{I_CFG_BE[0]}}};
    assign wd    = I_CFG_WDATA;
    // whole extended region reads as reserved in subtractive mode
    assign blank = I_SUBTR_DEC_EN && (waddr >= OFS_EXT_LO);

    always_comb begin
        hit     = 1'b1;
        rd_word = '0;
        case (waddr)
            OFS_VENDOR:     rd_word = {DEVICE_CODE, VENDOR_CODE};
            OFS_ERR_CAP:    rd_word = {NEXT_ERR, CAP_VER, CAPID_ERR};
            OFS_UNC_FLAGS:  rd_word = unc_flags;
            OFS_UNC_MASK:   rd_word = unc_mask_q;
            OFS_UNC_SEV:    rd_word = unc_sev_q;
            OFS_COR_FLAGS:  rd_word = cor_flags;
            OFS_COR_MASK:   rd_word = cor_mask_q;
            OFS_ERR_CTRL:   rd_word = ctrl_q | 32'(fep_q);
            OFS_SEC_FLAGS:  rd_word = sec_flags;
            OFS_SEC_MASK:   rd_word = sec_mask_q;
            OFS_SEC_SEV:    rd_word = sec_sev_q;
            OFS_SEC_CTRL:   rd_word = sec_ctrl_q | 32'(sec_fep_q);
            OFS_CH_CAP:     rd_word = {NEXT_CH, CAP_VER, CAPID_CH};
            OFS_PCH_CAPS1:  rd_word = PCH_CAPS1_VAL;
            OFS_PCH_CAPS2:  rd_word = PCH_CAPS2_VAL;
            OFS_PCH_STCTRL: rd_word = pch_q;
            OFS_CH0_RCAPS:  rd_word = CH0_RCAPS_VAL;
            OFS_CH0_RCTRL:  rd_word = ch0_q | CH0_RCTRL_FIX;
            OFS_CH0_RSTAT:  rd_word = CH0_RSTAT_VAL;
            OFS_PIN_DATA:   rd_word = pin_q | (32'(pin_s2_q) << PIN_IN_LSB);
            OFS_IO_DATA:    rd_word = io_q | (32'(gen_s2_q) << IO_IN_LSB);
            OFS_REPLAY:     rd_word = replay_q;
            default: begin
                if (hrel < HDR_BYTES) begin
                    rd_word = hdr_q[hrel[3:2]];
                end else if (srel < HDR_BYTES) begin
                    rd_word = sec_hdr_q[srel[3:2]];
                end else begin
                    hit = 1'b0;
                end
            end
        endcase
    end

    // SMBus may not write the error capability header at 100h; EEPROM preloads only
    // the uncorrectable mask and the replay timer
    always_comb begin
        case (I_CFG_SRC)
            SRC_HOST:   src_ok = 1'b1;
            SRC_SMBUS:  src_ok = !I_CFG_WE || (waddr != OFS_ERR_CAP);
            SRC_EEPROM: src_ok = I_CFG_WE && ((waddr == OFS_UNC_MASK) ||
                                 (waddr == OFS_REPLAY));
            default:    src_ok = 1'b0;
        endcase
    end

    assign acc_rd = I_CFG_REQ && !I_CFG_WE && hit && !blank && src_ok;
    assign acc_wr = I_CFG_REQ && I_CFG_WE && hit && !blank && src_ok;

    always_comb begin
        ack_d   = I_CFG_REQ;
        rdata_d = rdata_q;
        if (I_CFG_REQ) begin
            rdata_d = acc_rd ? rd_word : '0;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ack_q   <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // ordinary (non-sticky) control state
    always_comb begin
        pin_d    = pin_q;
        io_d     = io_q;
        replay_d = replay_q;
        pch_d    = pch_q;
        ch0_d    = ch0_q;
        if (acc_wr) begin
            case (waddr)
                OFS_PIN_DATA:   pin_d = merge(pin_q, wd, bm & PIN_WMASK);
                OFS_IO_DATA:    io_d  = merge(io_q, wd, bm & IO_WMASK);
                OFS_REPLAY:     replay_d = merge(replay_q, wd, bm);
                OFS_PCH_STCTRL: pch_d = merge(pch_q, wd, bm & PCH_WMASK);
                OFS_CH0_RCTRL:  ch0_d = merge(ch0_q, wd, bm & CH0_WMASK);
                default:        pin_d = pin_q;
            endcase
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            pin_q    <= '0;
            io_q     <= '0;
            replay_q <= REPLAY_RST;
            pch_q    <= '0;
            ch0_q    <= CH0_RCTRL_RST;
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            gen_s1_q <= '0;
            gen_s2_q <= '0;
        end else begin
            pin_q    <= pin_d;
            io_q     <= io_d;
            replay_q <= replay_d;
            pch_q    <= pch_d;
            ch0_q    <= ch0_d;
            pin_s1_q <= I_XPIN_IN;
            pin_s2_q <= pin_s1_q;
            gen_s1_q <= I_GEN_IN;
            gen_s2_q <= gen_s1_q;
        end
    end

    assign O_XPIN_OUT     = pin_q[PIN_OUT_LSB +: PIN_W];
    assign O_XPIN_OE_N    = ~pin_q[PIN_OE_LSB +: PIN_W];
    assign O_GEN_OUT      = io_q[IO_OUT_LSB +: PIN_W];
    assign O_REPLAY_TIMER = replay_q;
    assign O_CFG_ACK      = ack_q;
    assign O_CFG_RDATA    = rdata_q;

    pcxcfg_w1c_cell #(.W(32)) u_unc (
        .i_clk       (I_REF_CLK),
        .i_pwr_rst_n (I_PWR_RESETN),
        .i_set       (I_UNC_ERR_SET),
        .i_clr_we    (acc_wr && (waddr == OFS_UNC_FLAGS)),
        .i_clr       (wd & bm),
        .o_flags     (unc_flags)
    );
    pcxcfg_w1c_cell #(.W(32)) u_cor (
        .i_clk       (I_REF_CLK),
        .i_pwr_rst_n (I_PWR_RESETN),
        .i_set       (I_COR_ERR_SET),
        .i_clr_we    (acc_wr && (waddr == OFS_COR_FLAGS)),
        .i_clr       (wd & bm),
        .o_flags     (cor_flags)
    );
    pcxcfg_w1c_cell #(.W(32)) u_sec (
        .i_clk       (I_REF_CLK),
        .i_pwr_rst_n (I_PWR_RESETN),
        .i_set       (I_SEC_UNC_SET),
        .i_clr_we    (acc_wr && (waddr == OFS_SEC_FLAGS)),
        .i_clr       (wd & bm),
        .o_flags     (sec_flags)
    );

    assign unc_new = I_UNC_ERR_SET & ~unc_mask_q;
    assign sec_new = I_SEC_UNC_SET & ~sec_mask_q;

    // sticky state; the log is taken only while no unmasked error is
    // pending, so the first error's header is not overwritten
    always_comb begin
        unc_mask_d = unc_mask_q;
        unc_sev_d  = unc_sev_q;
        cor_mask_d = cor_mask_q;
        ctrl_d     = ctrl_q;
        fep_d      = fep_q;
        hdr_d      = hdr_q;
        sec_mask_d = sec_mask_q;
        sec_sev_d  = sec_sev_q;
        sec_ctrl_d = sec_ctrl_q;
        sec_fep_d  = sec_fep_q;
        sec_hdr_d  = sec_hdr_q;
        if (acc_wr) begin
            case (waddr)
                OFS_UNC_MASK: unc_mask_d = merge(unc_mask_q, wd, bm);
                OFS_UNC_SEV:  unc_sev_d  = merge(unc_sev_q, wd, bm);
                OFS_COR_MASK: cor_mask_d = merge(cor_mask_q, wd, bm);
                OFS_ERR_CTRL: ctrl_d = merge(ctrl_q, wd, bm & CTRL_WMASK);
                OFS_SEC_MASK: sec_mask_d = merge(sec_mask_q, wd, bm);
                OFS_SEC_SEV:  sec_sev_d  = merge(sec_sev_q, wd, bm);
                OFS_SEC_CTRL: sec_ctrl_d = merge(sec_ctrl_q, wd,
                                                 bm & CTRL_WMASK);
                default:      ctrl_d = ctrl_q; // logs ignore writes
            endcase
        end
        if ((|unc_new) && !(|(unc_flags & ~unc_mask_q))) begin
            hdr_d = I_HDR_LOG;
            fep_d = low_idx(unc_new);
        end
        if ((|sec_new) && !(|(sec_flags & ~sec_mask_q))) begin
            sec_hdr_d = I_SEC_HDR_LOG;
            sec_fep_d = low_idx(sec_new);
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_PWR_RESETN) begin
        if (!I_PWR_RESETN) begin
            unc_mask_q <= UNC_MASK_RST;
            unc_sev_q  <= UNC_SEV_RST;
            cor_mask_q <= COR_MASK_RST;
            ctrl_q     <= '0;
            fep_q      <= '0;
            hdr_q      <= '0;
            sec_mask_q <= UNC_MASK_RST;
            sec_sev_q  <= SEC_SEV_RST;
            sec_ctrl_q <= '0;
            sec_fep_q  <= '0;
            sec_hdr_q  <= '0;
        end else begin
            unc_mask_q <= unc_mask_d;
            unc_sev_q  <= unc_sev_d;
            cor_mask_q <= cor_mask_d;
            ctrl_q     <= ctrl_d;
            fep_q      <= fep_d;
            hdr_q      <= hdr_d;
            sec_mask_q <= sec_mask_d;
            sec_sev_q  <= sec_sev_d;
            sec_ctrl_q <= sec_ctrl_d;
            sec_fep_q  <= sec_fep_d;
            sec_hdr_q  <= sec_hdr_d;
        end
    end

    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RESETN);

    // a plain boolean so that it can be combined with other terms
    function automatic logic host_rd(input logic [11:0] a);
        return I_CFG_REQ && !I_CFG_WE && (I_CFG_SRC == SRC_HOST) &&
               (waddr == a);
    endfunction

    a_ext_replay: assert property (
        host_rd(OFS_REPLAY) && !I_SUBTR_DEC_EN
        |=> O_CFG_ACK && (O_CFG_RDATA == O_REPLAY_TIMER))
        else $error("replay timer read wrong");
    a_err_cap_id: assert property (
        host_rd(OFS_ERR_CAP) && !I_SUBTR_DEC_EN
        |=> O_CFG_RDATA[15:0] == CAPID_ERR)
        else $error("error capability id wrong");
    a_ch_cap_id: assert property (
        host_rd(OFS_CH_CAP) && !I_SUBTR_DEC_EN
        |=> O_CFG_RDATA == {NEXT_CH, CAP_VER, CAPID_CH})
        else $error("channel capability header wrong");
    a_subtr_blank: assert property (
        I_CFG_REQ && !I_CFG_WE && I_SUBTR_DEC_EN && (waddr >= OFS_EXT_LO)
        |=> O_CFG_ACK && (O_CFG_RDATA == 32'h0000_0000))
        else $error("subtractive mode read not blank");
    a_pin_no_preload: assert property (
        I_CFG_REQ && I_CFG_WE && (I_CFG_SRC == SRC_EEPROM) &&
        (waddr == OFS_PIN_DATA) |=> $stable(O_XPIN_OUT) && $stable(O_XPIN_OE_N))
        else $error("pin register preloaded");
    a_io_no_preload: assert property (
        I_CFG_REQ && I_CFG_WE && (I_CFG_SRC == SRC_EEPROM) &&
        (waddr == OFS_IO_DATA) |=> $stable(O_GEN_OUT))
        else $error("output register preloaded");
    a_sticky_hold: assert property (
        @(posedge I_REF_CLK) disable iff (!I_PWR_RESETN)
        !I_RESETN && !(|I_UNC_ERR_SET) |=> $stable(unc_flags))
        else $error("sticky flags lost on ordinary reset");
    a_log_ro: assert property (
        I_CFG_REQ && I_CFG_WE && (waddr == OFS_HDR_LOG) && !(|unc_new)
        |=> $stable(hdr_q))
        else $error("header log took a write");
    a_ident_word: assert property (
        host_rd(OFS_VENDOR)
        |=> O_CFG_RDATA == {DEVICE_CODE, VENDOR_CODE})
        else $error("identity word wrong");
    a_reserved_zero: assert property (
        I_CFG_REQ && !I_CFG_WE && (waddr >= 12'h16c) && (waddr < 12'h300)
        ##1 O_CFG_ACK |-> O_CFG_RDATA == 32'h0000_0000)
        else $error("reserved offset not zero");

    c_smbus_pin: cover property (
        I_CFG_REQ && I_CFG_WE && (I_CFG_SRC == SRC_SMBUS) &&
        (waddr == OFS_PIN_DATA));
    c_log_capture: cover property ((|unc_new) && !(|unc_flags));
    c_subtr_read: cover property (host_rd(OFS_ERR_CAP) && I_SUBTR_DEC_EN);
endmodule
`default_nettype wire

// ===== rtl/pcxcfg_pkg.sv
// Behaviour
// - decode extended config offsets 100h to FFFh, 3840 bytes in all.
// - error-reporting capability header at 100h with capability id 0001h.
// - virtual-channel capability header at 150h with capability id 0002h.
// - subtractive decode on: whole extended region reads zero, ignores writes.
// - pin data/control at 300h reachable by SMBus, never EEPROM-preloaded.
// - input/output data/control at 304h reachable by SMBus, no EEPROM preload.
// - write-one-clear fields clear bits written one, keep bits written zero.
// - write-one-clear sticky fields survive ordinary reset, cleared at power-up.
// - read-only sticky fields ignore writes and keep value over ordinary reset.
// - fixed vendor code in bits 15:0 at offset 00h, writes ignored.
// - fixed device code in bits 31:16 at offset 00h, read-only.
`default_nettype none
package pcxcfg_pkg;
    localparam int          AW             = 12;
    localparam int          DW             = 32;
    localparam int          PIN_W          = 8;
    localparam logic [11:0] OFS_VENDOR     = 12'h000;
    localparam logic [11:0] OFS_EXT_LO     = 12'h100;
    localparam logic [11:0] OFS_ERR_CAP    = 12'h100;
    localparam logic [11:0] OFS_UNC_FLAGS  = 12'h104;
    localparam logic [11:0] OFS_UNC_MASK   = 12'h108;
    localparam logic [11:0] OFS_UNC_SEV    = 12'h10c;
    localparam logic [11:0] OFS_COR_FLAGS  = 12'h110;
    localparam logic [11:0] OFS_COR_MASK   = 12'h114;
    localparam logic [11:0] OFS_ERR_CTRL   = 12'h118;
    localparam logic [11:0] OFS_HDR_LOG    = 12'h11c;
    localparam logic [11:0] OFS_SEC_FLAGS  = 12'h12c;
    localparam logic [11:0] OFS_SEC_MASK   = 12'h130;
    localparam logic [11:0] OFS_SEC_SEV    = 12'h134;
    localparam logic [11:0] OFS_SEC_CTRL   = 12'h138;
    localparam logic [11:0] OFS_SEC_HDR    = 12'h13c;
    localparam logic [11:0] OFS_CH_CAP     = 12'h150;
    localparam logic [11:0] OFS_PCH_CAPS1  = 12'h154;
    localparam logic [11:0] OFS_PCH_CAPS2  = 12'h158;
    localparam logic [11:0] OFS_PCH_STCTRL = 12'h15c;
    localparam logic [11:0] OFS_CH0_RCAPS  = 12'h160;
    localparam logic [11:0] OFS_CH0_RCTRL  = 12'h164;
    localparam logic [11:0] OFS_CH0_RSTAT  = 12'h168;
    localparam logic [11:0] OFS_PIN_DATA   = 12'h300;
    localparam logic [11:0] OFS_IO_DATA    = 12'h304;
    localparam logic [11:0] OFS_REPLAY     = 12'h310;
    localparam logic [11:0] HDR_BYTES      = 12'h010;
    localparam logic [15:0] CAPID_ERR      = 16'h0001;
    localparam logic [15:0] CAPID_CH       = 16'h0002;
    localparam logic [3:0]  CAP_VER        = 4'h1;
    localparam logic [11:0] NEXT_ERR       = 12'h150;
    localparam logic [11:0] NEXT_CH        = 12'h000;
    localparam logic [31:0] UNC_MASK_RST   = 32'h0000_0000;
    localparam logic [31:0] UNC_SEV_RST    = 32'h0006_2030;
    localparam logic [31:0] COR_MASK_RST   = 32'h0000_0000;
    localparam logic [31:0] SEC_SEV_RST    = 32'h0000_1340;
    localparam logic [31:0] CTRL_WMASK     = 32'h0000_0140;
    localparam logic [31:0] PCH_CAPS1_VAL  = 32'h0000_0000;
    localparam logic [31:0] PCH_CAPS2_VAL  = 32'h0000_0000;
    localparam logic [31:0] PCH_WMASK      = 32'h0000_000e;
    localparam logic [31:0] CH0_RCAPS_VAL  = 32'h0000_0000;
    localparam logic [31:0] CH0_RCTRL_FIX  = 32'h8000_0001;
    localparam logic [31:0] CH0_RCTRL_RST  = 32'h0000_00fe;
    localparam logic [31:0] CH0_WMASK      = 32'h0000_00fe;
    localparam logic [31:0] CH0_RSTAT_VAL  = 32'h0000_0000;
    localparam int          PIN_OE_LSB     = 0;
    localparam int          PIN_OUT_LSB    = 8;
    localparam int          PIN_IN_LSB     = 16;
    localparam logic [31:0] PIN_WMASK      = 32'h0000_ffff;
    localparam int          IO_IN_LSB      = 0;
    localparam int          IO_OUT_LSB     = 8;
    localparam logic [31:0] IO_WMASK       = 32'h0000_ff00;
    typedef enum logic [1:0] {
        SRC_HOST   = 2'h0,
        SRC_SMBUS  = 2'h1,
        SRC_EEPROM = 2'h2
    } pcxcfg_src_t;
endpackage
`default_nettype wire

// ===== rtl/pcxcfg_w1c_cell.sv
`timescale 1ns/100ps
`default_nettype none
module pcxcfg_w1c_cell #(
    parameter int W = 32
) (
    input  wire logic         i_clk,
    input  wire logic         i_pwr_rst_n,
    input  wire logic [W-1:0] i_set,
    input  wire logic         i_clr_we,
    input  wire logic [W-1:0] i_clr,
    output logic      [W-1:0] o_flags
);
    logic [W-1:0] flags_q;
    logic [W-1:0] flags_d;

    // set ORed in last so an event in the clearing cycle is kept
    always_comb begin
        flags_d = flags_q;
        if (i_clr_we) begin
            flags_d = flags_q & ~i_clr;
        end
        flags_d = flags_d | i_set;
    end

    // only power-up reset clears these
    always_ff @(posedge i_clk or negedge i_pwr_rst_n) begin
        if (!i_pwr_rst_n) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign o_flags = flags_q;

    a_set_wins: assert property (
        @(posedge i_clk) disable iff (!i_pwr_rst_n)
        (|i_set) |=> ((flags_q & $past(i_set)) == $past(i_set)))
        else $error("flag event lost");
    a_clr_ones: assert property (
        @(posedge i_clk) disable iff (!i_pwr_rst_n)
        (i_clr_we && !(|i_set))
        |=> (flags_q == ($past(flags_q) & ~$past(i_clr))))
        else $error("one-to-clear wrong");
    c_clr_race: cover property (
        @(posedge i_clk) disable iff (!i_pwr_rst_n)
        i_clr_we && |(i_set & i_clr));
endmodule
`default_nettype wire

// ===== sim/pcxcfg_ext_space_tb.sv
`timescale 1ns/100ps
`default_nettype none
module pcxcfg_ext_space_tb;
    import pcxcfg_pkg::*;
    localparam logic [15:0] VEN = 16'h5a5a; // arbitrary value
    localparam logic [15:0] DEV = 16'h7e31; // arbitrary value
    logic clk = 1'b0, rst_n = 1'b0, pwr_n = 1'b0, sub = 1'b0;
    logic [31:0] ev = '0, wd, rd, q, r, rt;
    logic [127:0] hl = '0;
    logic [7:0] pin, gin, xo, xoe, go;
    logic req, we, ack;
    pcxcfg_src_t src;
    logic [11:0] addr;
    logic [31:0] mdl [int];
    logic [11:0] rsv [5] = '{12'h14c, 12'h16c, 12'h2fc, 12'h308, 12'hffc};
    int miscompares = 0, checks = 0, cyc = 0;
    pcxcfg_rc_model rc (.i_clk(clk), .i_ack(ack), .i_rdata(rd), .o_req(req),
        .o_we(we), .o_src(src), .o_addr(addr), .o_wdata(wd));
    pcxcfg_ext_space #(.VENDOR_CODE(VEN), .DEVICE_CODE(DEV)) dut (
        .I_REF_CLK(clk), .I_RESETN(rst_n), .I_PWR_RESETN(pwr_n),
        .I_SUBTR_DEC_EN(sub), .I_CFG_REQ(req), .I_CFG_WE(we),
        .I_CFG_SRC(src), .I_CFG_ADDR(addr), .I_CFG_BE(4'hf),
        .I_CFG_WDATA(wd), .O_CFG_ACK(ack), .O_CFG_RDATA(rd),
        .I_UNC_ERR_SET(ev), .I_COR_ERR_SET(ev), .I_SEC_UNC_SET(ev),
        .I_HDR_LOG(hl), .I_SEC_HDR_LOG(hl), .I_XPIN_IN(pin),
        .O_XPIN_OUT(xo), .O_XPIN_OE_N(xoe), .I_GEN_IN(gin),
        .O_GEN_OUT(go), .O_REPLAY_TIMER(rt));
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input pcxcfg_src_t s, input logic [11:0] a,
                      input logic [31:0] d);
        rc.xfer(1'b1, s, a, d, q);
    endtask
    // blanking mode hides everything from 100h upward
    task automatic rck(input logic [11:0] a);
        logic [31:0] e;
        e = (sub && a >= 12'h100) || !mdl.exists(a) ? '0 : mdl[a];
        rc.xfer(1'b0, SRC_HOST, a, '0, q);
        chk(q, e);
    endtask
    task automatic sweep;
        foreach (mdl[a]) rck(a[11:0]);
        foreach (rsv[i]) rck(rsv[i]);
    endtask
    task automatic set_ev(input logic [31:0] f, input logic [127:0] h);
        mdl[12'h104] = f;
        mdl[12'h110] = f;
        mdl[12'h12c] = f;
        for (int i = 0; i < 4; i++) begin
            mdl[12'h11c + 4 * i] = h[32 * i +: 32];
            mdl[12'h13c + 4 * i] = h[32 * i +: 32];
        end
    endtask
    task print_verdict;
        miscompares += rc.lost;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'he41da71e));
        pin = 8'($urandom);
        gin = 8'($urandom);
        mdl[0] = {DEV, VEN};
        mdl[12'h100] = {NEXT_ERR, CAP_VER, CAPID_ERR};
        mdl[12'h150] = {NEXT_CH, CAP_VER, CAPID_CH};
        mdl[12'h10c] = UNC_SEV_RST;
        mdl[12'h134] = SEC_SEV_RST;
        mdl[12'h164] = CH0_RCTRL_FIX | CH0_RCTRL_RST;
        mdl[12'h300] = {8'h00, pin, 16'h0000};
        mdl[12'h304] = {24'h0, gin};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        pwr_n <= 1'b1;
        wr(SRC_HOST, 12'h000, '1);
        wr(SRC_SMBUS, 12'h100, '1);
        wr(SRC_HOST, 12'h150, '1);
        foreach (rsv[i]) wr(SRC_SMBUS, rsv[i], '1);
        sweep();
        r = $urandom;
        wr(SRC_EEPROM, 12'h310, r);
        mdl[12'h310] = r;
        rck(12'h310);
        chk(rt, r);
        wr(SRC_EEPROM, 12'h300, r);
        wr(SRC_EEPROM, 12'h304, r);
        rck(12'h300);
        rck(12'h304);
        wr(SRC_SMBUS, 12'h300, r);
        wr(SRC_SMBUS, 12'h304, r);
        mdl[12'h300][15:0] = r[15:0];
        mdl[12'h304][15:8] = r[15:8];
        sweep();
        chk({8'h0, xo, xoe, go}, {8'h0, r[15:8], ~r[7:0], r[15:8]});
        @(posedge clk);
        ev <= 32'h0000_1010;
        hl <= {$urandom, $urandom, $urandom, $urandom};
        @(posedge clk);
        ev <= '0;
        set_ev(32'h0000_1010, hl);
        mdl[12'h118] = 32'h4;
        mdl[12'h138] = 32'h4;
        wr(SRC_HOST, 12'h11c, '1);
        sweep();
        mdl.delete(12'h118);
        mdl.delete(12'h138);
        wr(SRC_SMBUS, 12'h104, 32'h0000_0010);
        mdl[12'h104] = 32'h0000_1000;
        rck(12'h104);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        mdl[12'h310] = '0;
        mdl[12'h300][15:0] = '0;
        mdl[12'h304][15:8] = '0;
        sweep();
        @(posedge clk);
        pwr_n <= 1'b0;
        @(posedge clk);
        pwr_n <= 1'b1;
        set_ev('0, '0);
        sweep();
        @(posedge clk);
        sub <= 1'b1;
        wr(SRC_HOST, 12'h310, '1);
        sweep();
        @(posedge clk);
        sub <= 1'b0;
        rck(12'h310);
        print_verdict();
    end
endmodule
`default_nettype wire

// ===== sim/pcxcfg_rc_model.sv
`timescale 1ns/100ps
`default_nettype none
module pcxcfg_rc_model (
    input  wire logic               i_clk,
    input  wire logic               i_ack,
    input  wire logic [31:0]        i_rdata,
    output logic                    o_req = 1'b0,
    output logic                    o_we = 1'b0,
    output pcxcfg_pkg::pcxcfg_src_t o_src = pcxcfg_pkg::SRC_HOST,
    output logic      [11:0]        o_addr = '0,
    output logic      [31:0]        o_wdata = '0
);
    import pcxcfg_pkg::*;
    int lost = 0;
    // request lasts one edge: holding it longer would count twice
    task automatic xfer(input logic w, input pcxcfg_src_t s,
                        input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge i_clk);
        o_req <= 1'b1;
        o_we <= w;
        o_src <= s;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_req <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
        #1;
        if (i_ack !== 1'b1) lost++;
        q = i_rdata;
    endtask
endmodule
`default_nettype wire
